// ### rtl/diag_history_pkg.sv
// constants shared by the diagnosis history object and its slot store
package diag_history_pkg;
   localparam int unsigned  CAPACITY          = 250;
   localparam logic [15:0]  HISTORY_INDEX     = 16'h10F3;
   localparam logic [7:0]   CAPACITY_VAL      = 8'hFA;
   localparam logic [7:0]   HIGHEST_SUPPORTED = 8'hFF;
   localparam logic [7:0]   FIRST_SLOT_SUB    = 8'h06;
   localparam logic [7:0]   LAST_SLOT_IDX     = 8'hF9;
   localparam logic [7:0]   SUB_HIGHEST       = 8'h00;
   localparam logic [7:0]   SUB_CAPACITY      = 8'h01;
   localparam logic [7:0]   SUB_NEWEST        = 8'h02;
   localparam logic [7:0]   SUB_ACK           = 8'h03;
   localparam logic [7:0]   SUB_NEW_FLAG      = 8'h04;
   localparam logic [7:0]   SUB_FLAGS         = 8'h05;
   localparam int unsigned  FLAG_EMCY         = 0;
   localparam int unsigned  FLAG_NO_INFO      = 1;
   localparam int unsigned  FLAG_NO_WARN      = 2;
   localparam int unsigned  FLAG_NO_ERROR     = 3;
   localparam int unsigned  FLAG_MODE         = 4;
   localparam int unsigned  FLAG_OVERFLOW     = 5;
   localparam int unsigned  FLAG_CTRL_W       = 5;
   localparam logic [4:0]   FLAGS_RESET       = 5'h00;
   localparam logic [31:0]  ABORT_TOO_LOW     = 32'h06090032;
   localparam logic [31:0]  ABORT_RANGE       = 32'h06090030;
   localparam logic [31:0]  ABORT_READ_ONLY   = 32'h06010002;
   localparam logic [31:0]  ABORT_NO_OBJECT   = 32'h06020000;
   localparam int unsigned  PAYLOAD_W         = 8;
   localparam int unsigned  ENTRY_W           = PAYLOAD_W + 2;
   localparam logic [1:0]   CLASS_INFO        = 2'h0;
   localparam logic [1:0]   CLASS_WARN        = 2'h1;
   localparam logic [1:0]   CLASS_ERROR       = 2'h2;
   localparam logic         EMCY_SUPPORTED    = 1'b1;
endpackage : diag_history_pkg

// ### rtl/diag_slot_store.sv
// ring of 250 message slots with per-slot valid and acknowledged marks
`timescale 1ns/1ps
module diag_slot_store (
   input  wire logic                                 clk,
   input  wire logic                                 nrst,
   input  wire logic                                 ce,
   input  wire logic                                 wr_en,
   input  wire logic [7:0]                           wr_slot,
   input  wire logic [diag_history_pkg::ENTRY_W-1:0] wr_entry,
   input  wire logic                                 ack_en,
   input  wire logic [7:0]                           ack_age,
   input  wire logic [7:0]                           newest_slot,
   input  wire logic                                 del_acked,
   input  wire logic                                 clr_all,
   input  wire logic [7:0]                           rd_slot,
   input  wire logic [7:0]                           head_slot,
   output logic      [diag_history_pkg::ENTRY_W-1:0] rd_entry,
   output logic                                      rd_valid,
   output logic                                      head_valid,
   output logic                                      head_acked,
   output logic                                      any_unacked,
   output logic      [7:0]                           highest_sub
);
   logic [diag_history_pkg::ENTRY_W-1:0] entry_r [diag_history_pkg::CAPACITY];
   logic [diag_history_pkg::CAPACITY-1:0] valid_r;
   logic [diag_history_pkg::CAPACITY-1:0] acked_r;
   logic [diag_history_pkg::CAPACITY-1:0] older_hit;

   genvar g;
   generate
      for (g = 0; g < diag_history_pkg::CAPACITY; g++) begin : g_slot
         logic [8:0] age;
         // age counts back from the newest slot around the ring
         always_comb begin
            if (newest_slot >= 8'(g))
               age = {1'b0, newest_slot} - 9'(g);
            else
               age = {1'b0, newest_slot} + 9'(diag_history_pkg::CAPACITY) - 9'(g);
         end
         assign older_hit[g] = valid_r[g] && (age[7:0] >= ack_age);

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               valid_r[g] <= 1'b0;
               acked_r[g] <= 1'b0;
            end else if (ce) begin
               if (clr_all) begin
                  valid_r[g] <= 1'b0;
                  acked_r[g] <= 1'b0;
               end else if (wr_en && wr_slot == 8'(g)) begin
                  valid_r[g] <= 1'b1;
                  acked_r[g] <= 1'b0;
               end else if (del_acked && acked_r[g]) begin
                  valid_r[g] <= 1'b0;
                  acked_r[g] <= 1'b0;
               end else if (ack_en && older_hit[g]) begin
                  acked_r[g] <= 1'b1;
               end
            end
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst)
               entry_r[g] <= '0;
            else if (ce && wr_en && wr_slot == 8'(g))
               entry_r[g] <= wr_entry;
         end
      end
   endgenerate

   always_comb begin
      rd_entry    = '0;
      rd_valid    = 1'b0;
      head_valid  = 1'b0;
      head_acked  = 1'b0;
      highest_sub = 8'h00;
      if (rd_slot < 8'(diag_history_pkg::CAPACITY)) begin
         rd_entry = entry_r[rd_slot];
         rd_valid = valid_r[rd_slot];
      end
      if (head_slot < 8'(diag_history_pkg::CAPACITY)) begin
         head_valid = valid_r[head_slot];
         head_acked = acked_r[head_slot];
      end
      for (int i = 0; i < diag_history_pkg::CAPACITY; i++) begin
         if (valid_r[i])
            highest_sub = 8'(i) + diag_history_pkg::FIRST_SLOT_SUB;
      end
   end

   assign any_unacked = |(valid_r & ~acked_r);
endmodule : diag_slot_store

// ### rtl/diag_history_log.sv
// diagnosis history object: message ring, pointers, flag word and object access port
`timescale 1ns/1ps
module diag_history_log (
   input  wire logic                                   clk,
   input  wire logic                                   nrst,
   input  wire logic                                   ce,
   input  wire logic                                   sdo_req,
   input  wire logic                                   sdo_write,
   input  wire logic [15:0]                            sdo_index,
   input  wire logic [7:0]                             sdo_subindex,
   input  wire logic [15:0]                            sdo_wdata,
   output logic                                        sdo_done,
   output logic      [15:0]                            sdo_rdata,
   output logic                                        sdo_abort,
   output logic      [31:0]                            sdo_abort_code,
   input  wire logic                                   msg_valid,
   input  wire logic [1:0]                             msg_class,
   input  wire logic [diag_history_pkg::PAYLOAD_W-1:0] msg_payload,
   output logic                                        msg_ready,
   output logic                                        emcy_valid,
   output logic      [diag_history_pkg::ENTRY_W-1:0]   emcy_entry
);
   logic [7:0]  head_r;
   logic [7:0]  newest_r;
   logic        stored_any_r;
   logic [7:0]  ack_ptr_r;
   logic [4:0]  flags_r;
   logic        overflow_r;
   logic        new_unread_r;

   logic [diag_history_pkg::ENTRY_W-1:0] rd_entry;
   logic        rd_valid;
   logic        head_valid;
   logic        head_acked;
   logic        any_unacked;
   logic [7:0]  highest_sub;

   logic        ack_mode;
   logic        take_req;
   logic        obj_hit;
   logic        is_slot_sub;
   logic [7:0]  slot_of_sub;
   logic [7:0]  wr_val;
   logic        wr_ack_ptr;
   logic        wr_flags;
   logic        ack_zero;
   logic        ack_too_low;
   logic        ack_empty;
   logic        ack_valid_sub;
   logic        msg_take;
   logic        msg_filtered;
   logic        msg_store;
   logic        msg_drop;
   logic        msg_clobber;
   logic [7:0]  ack_age;
   logic [7:0]  next_head;
   logic [15:0] rdata_nxt;
   logic [31:0] abort_nxt;
   logic        abort_hit;

   assign ack_mode  = flags_r[diag_history_pkg::FLAG_MODE];
   assign take_req  = ce && sdo_req;
   assign obj_hit   = (sdo_index == diag_history_pkg::HISTORY_INDEX);
   assign is_slot_sub = (sdo_subindex >= diag_history_pkg::FIRST_SLOT_SUB);
   assign slot_of_sub = sdo_subindex - diag_history_pkg::FIRST_SLOT_SUB;
   assign wr_val    = sdo_wdata[7:0];

   // the store is looked up at the written pointer value during pointer writes
   logic [7:0] rd_slot_sel;
   assign rd_slot_sel = (sdo_write && sdo_subindex == diag_history_pkg::SUB_ACK)
                        ? (wr_val - diag_history_pkg::FIRST_SLOT_SUB) : slot_of_sub;

   // ---------------- pointer write decode ----------------
   assign ack_zero      = (wr_val == 8'h00);
   assign ack_too_low   = !ack_zero && (wr_val < diag_history_pkg::FIRST_SLOT_SUB);
   assign ack_empty     = !ack_zero && !ack_too_low && !rd_valid;
   assign ack_valid_sub = !ack_zero && !ack_too_low && rd_valid;

   always_comb begin
      abort_nxt = 32'h00000000;
      abort_hit = 1'b0;
      if (!obj_hit) begin
         abort_nxt = diag_history_pkg::ABORT_NO_OBJECT;
         abort_hit = 1'b1;
      end else if (sdo_write) begin
         case (sdo_subindex)
            diag_history_pkg::SUB_ACK: begin
               if (ack_too_low) begin
                  abort_nxt = diag_history_pkg::ABORT_TOO_LOW;
                  abort_hit = 1'b1;
               end else if (ack_empty) begin
                  abort_nxt = diag_history_pkg::ABORT_RANGE;
                  abort_hit = 1'b1;
               end
            end
            diag_history_pkg::SUB_FLAGS: begin
               abort_hit = 1'b0;
            end
            default: begin
               abort_nxt = diag_history_pkg::ABORT_READ_ONLY;
               abort_hit = 1'b1;
            end
         endcase
      end
   end

   assign wr_ack_ptr = take_req && obj_hit && sdo_write && (sdo_subindex == diag_history_pkg::SUB_ACK) && !abort_hit;
   assign wr_flags   = take_req && obj_hit && sdo_write && (sdo_subindex == diag_history_pkg::SUB_FLAGS);

   // age of the pointer target in slots, counted back from the newest message
   assign ack_age = (newest_r >= rd_slot_sel) ? (newest_r - rd_slot_sel)
                    : 8'(9'(newest_r) + 9'(diag_history_pkg::CAPACITY) - 9'(rd_slot_sel));

   // ---------------- message intake ----------------
   // messages wait while an object access is taken so both never touch the ring at once
   assign msg_ready = ce && !sdo_req;
   assign msg_take  = msg_valid && msg_ready;

   always_comb begin
      case (msg_class)
         diag_history_pkg::CLASS_INFO:  msg_filtered = flags_r[diag_history_pkg::FLAG_NO_INFO];
         diag_history_pkg::CLASS_WARN:  msg_filtered = flags_r[diag_history_pkg::FLAG_NO_WARN];
         diag_history_pkg::CLASS_ERROR: msg_filtered = flags_r[diag_history_pkg::FLAG_NO_ERROR];
         default:                       msg_filtered = 1'b0;
      endcase
   end

   // a valid head slot means the ring is full and the head holds the oldest message
   assign msg_drop    = msg_take && !msg_filtered && ack_mode && head_valid && !head_acked;
   assign msg_store   = msg_take && !msg_filtered && !msg_drop;
   assign msg_clobber = msg_store && head_valid && !head_acked;
   assign next_head   = (head_r == diag_history_pkg::LAST_SLOT_IDX) ? 8'h00 : head_r + 8'h01;

   diag_slot_store u_store (
      .clk         (clk),
      .nrst        (nrst),
      .ce          (ce),
      .wr_en       (msg_store),
      .wr_slot     (head_r),
      .wr_entry    ({msg_class, msg_payload}),
      .ack_en      (wr_ack_ptr && ack_valid_sub),
      .ack_age     (ack_age),
      .newest_slot (newest_r),
      .del_acked   (wr_ack_ptr && ack_zero && ack_mode),
      .clr_all     (wr_ack_ptr && ack_zero && !ack_mode),
      .rd_slot     (rd_slot_sel),
      .head_slot   (head_r),
      .rd_entry    (rd_entry),
      .rd_valid    (rd_valid),
      .head_valid  (head_valid),
      .head_acked  (head_acked),
      .any_unacked (any_unacked),
      .highest_sub (highest_sub)
   );

   // ---------------- ring position ----------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         head_r       <= 8'h00;
         newest_r     <= 8'h00;
         stored_any_r <= 1'b0;
      end else if (ce) begin
         if (wr_ack_ptr && ack_zero && !ack_mode) begin
            head_r       <= 8'h00;
            stored_any_r <= 1'b0;
         end else if (msg_store) begin
            head_r       <= next_head;
            newest_r     <= head_r;
            stored_any_r <= 1'b1;
         end else if (wr_ack_ptr && ack_zero && ack_mode && !any_unacked) begin
            stored_any_r <= 1'b0;
         end
      end
   end

   // ---------------- acknowledged pointer ----------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_ptr_r <= 8'h00;
      end else if (ce) begin
         if (wr_ack_ptr) begin
            ack_ptr_r <= wr_val;
            if (ack_zero)
               ack_ptr_r <= 8'h00;
         end else if (msg_clobber) begin
            ack_ptr_r <= 8'h00;
         end else if (msg_store && head_valid &&
                      ack_ptr_r == head_r + diag_history_pkg::FIRST_SLOT_SUB) begin
            // the acknowledged message itself was replaced, so the pointer no longer names it
            ack_ptr_r <= 8'h00;
         end
      end
   end

   // ---------------- flag word ----------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_r <= diag_history_pkg::FLAGS_RESET;
      end else if (ce && wr_flags) begin
         // bit 5 and the reserved bits are simply not stored
         flags_r <= sdo_wdata[diag_history_pkg::FLAG_CTRL_W-1:0];
         flags_r[diag_history_pkg::FLAG_EMCY] <= sdo_wdata[diag_history_pkg::FLAG_EMCY]
                                                 && diag_history_pkg::EMCY_SUPPORTED;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         overflow_r <= 1'b0;
      end else if (ce) begin
         if (msg_drop || msg_clobber)
            overflow_r <= 1'b1;
         else if (wr_ack_ptr && ack_zero && !ack_mode)
            overflow_r <= 1'b0;
      end
   end

   // overwrite-mode unread mark: set by a new message, cleared by reading the newest slot
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         new_unread_r <= 1'b0;
      end else if (ce) begin
         if (msg_store)
            new_unread_r <= 1'b1;
         else if (wr_ack_ptr && ack_zero && !ack_mode)
            new_unread_r <= 1'b0;
         else if (take_req && obj_hit && !sdo_write && is_slot_sub && slot_of_sub == newest_r)
            new_unread_r <= 1'b0;
      end
   end

   // ---------------- read data ----------------
   always_comb begin
      rdata_nxt = 16'h0000;
      case (sdo_subindex)
         diag_history_pkg::SUB_HIGHEST:
            rdata_nxt = {8'h00, highest_sub};
         diag_history_pkg::SUB_CAPACITY:
            rdata_nxt = {8'h00, diag_history_pkg::CAPACITY_VAL};
         diag_history_pkg::SUB_NEWEST:
            rdata_nxt = stored_any_r ? {8'h00, newest_r + diag_history_pkg::FIRST_SLOT_SUB} : 16'h0000;
         diag_history_pkg::SUB_ACK:
            rdata_nxt = {8'h00, ack_ptr_r};
         diag_history_pkg::SUB_NEW_FLAG:
            rdata_nxt = {15'h0000, ack_mode ? any_unacked : new_unread_r};
         diag_history_pkg::SUB_FLAGS:
            rdata_nxt = {10'h000, overflow_r, flags_r};
         default:
            rdata_nxt = rd_valid ? {{(16 - diag_history_pkg::ENTRY_W){1'b0}}, rd_entry} : 16'h0000;
      endcase
   end

   // answers are registered one cycle after the request is taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sdo_done       <= 1'b0;
         sdo_rdata      <= 16'h0000;
         sdo_abort      <= 1'b0;
         sdo_abort_code <= 32'h00000000;
      end else if (ce) begin
         sdo_done       <= sdo_req;
         sdo_abort      <= sdo_req && abort_hit;
         sdo_abort_code <= (sdo_req && abort_hit) ? abort_nxt : 32'h00000000;
         sdo_rdata      <= (sdo_req && !sdo_write && obj_hit) ? rdata_nxt : 16'h0000;
      end
   end

   // ---------------- emergency copy ----------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         emcy_valid <= 1'b0;
         emcy_entry <= '0;
      end else if (ce) begin
         emcy_valid <= msg_store && flags_r[diag_history_pkg::FLAG_EMCY];
         if (msg_store)
            emcy_entry <= {msg_class, msg_payload};
      end
   end
endmodule : diag_history_log

// ### bench/diag_history_log_properties.sv
// port-level assertions for the diagnosis history object
`timescale 1ns/1ps
module diag_history_log_checker (
   input wire logic                                   clk,
   input wire logic                                   nrst,
   input wire logic                                   ce,
   input wire logic                                   sdo_req,
   input wire logic                                   sdo_write,
   input wire logic [15:0]                            sdo_index,
   input wire logic [7:0]                             sdo_subindex,
   input wire logic [15:0]                            sdo_wdata,
   input wire logic                                   sdo_done,
   input wire logic [15:0]                            sdo_rdata,
   input wire logic                                   sdo_abort,
   input wire logic [31:0]                            sdo_abort_code,
   input wire logic                                   msg_valid,
   input wire logic [1:0]                             msg_class,
   input wire logic [diag_history_pkg::PAYLOAD_W-1:0] msg_payload,
   input wire logic                                   msg_ready,
   input wire logic                                   emcy_valid,
   input wire logic [diag_history_pkg::ENTRY_W-1:0]   emcy_entry
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic sdo_take;
   logic obj_rd;
   logic obj_wr;
   assign sdo_take = ce && sdo_req;
   assign obj_rd   = sdo_take && !sdo_write && sdo_index == diag_history_pkg::HISTORY_INDEX;
   assign obj_wr   = sdo_take && sdo_write && sdo_index == diag_history_pkg::HISTORY_INDEX;
   chk_answer_next: assert property (sdo_take |=> sdo_done) else $error("access not answered");
   chk_no_stray_done: assert property ($past(ce) && !$past(sdo_take) |-> !sdo_done)
      else $error("answer without access");
   chk_too_low_code: assert property (obj_wr && sdo_subindex == 8'h03 && sdo_wdata[7:0] inside {[1:5]}
      |=> sdo_abort && sdo_abort_code == diag_history_pkg::ABORT_TOO_LOW) else $error("low pointer accepted");
   chk_capacity_read: assert property (obj_rd && sdo_subindex == 8'h01
      |=> !sdo_abort && sdo_rdata == 16'h00FA) else $error("capacity wrong");
   chk_ro_entries: assert property (obj_wr && sdo_subindex inside {8'h00, 8'h01, 8'h02}
      |=> sdo_abort) else $error("read-only entry written");
   chk_clean_code: assert property (sdo_done && !sdo_abort |-> sdo_abort_code == 32'h0)
      else $error("code without abort");
   chk_abort_no_data: assert property (sdo_done && sdo_abort |-> sdo_rdata == 16'h0)
      else $error("data with abort");
   chk_msg_gate: assert property (msg_ready == (ce && !sdo_req)) else $error("message gate wrong");
   // outputs freeze while ce is low, so only a pulse launched by an enabled edge is traced back
   chk_emcy_cause: assert property (emcy_valid && $past(ce) |-> $past(msg_valid && msg_ready))
      else $error("emergency without message");
   chk_reserved_zero: assert property (obj_rd && sdo_subindex == 8'h05 |=> sdo_rdata[15:6] == 10'h0)
      else $error("reserved flag bits set");
   chk_flag_write_ok: assert property (obj_wr && sdo_subindex == 8'h05 |=> sdo_done && !sdo_abort)
      else $error("flag write refused");
endmodule : diag_history_log_checker
bind diag_history_log diag_history_log_checker chk_u (.clk(clk), .nrst(nrst), .ce(ce), .sdo_req(sdo_req),
   .sdo_write(sdo_write), .sdo_index(sdo_index), .sdo_subindex(sdo_subindex), .sdo_wdata(sdo_wdata),
   .sdo_done(sdo_done), .sdo_rdata(sdo_rdata), .sdo_abort(sdo_abort), .sdo_abort_code(sdo_abort_code),
   .msg_valid(msg_valid), .msg_class(msg_class), .msg_payload(msg_payload), .msg_ready(msg_ready),
   .emcy_valid(emcy_valid), .emcy_entry(emcy_entry));

// ### bench/sdo_master_model.sv
// fieldbus master model issuing single object accesses
`timescale 1ns/1ps
module sdo_master_model (
   input  wire logic        clk,
   input  wire logic        sdo_done,
   input  wire logic [15:0] sdo_rdata,
   input  wire logic [31:0] sdo_abort_code,
   output logic             sdo_req,
   output logic             sdo_write,
   output logic      [15:0] sdo_index,
   output logic      [7:0]  sdo_subindex,
   output logic      [15:0] sdo_wdata
);
   // object index of the next access; the bench may point it at a foreign object
   logic [15:0] access_index = diag_history_pkg::HISTORY_INDEX;
   initial begin
      sdo_req = 1'b0;
      sdo_write = 1'b0;
      sdo_index = 16'h0000;
      sdo_subindex = 8'h00;
      sdo_wdata = 16'h0000;
   end
   task automatic access(input logic wr, input logic [7:0] sub, input logic [15:0] wd,
                         output logic [15:0] rd, output logic [31:0] code);
      int i;
      @(negedge clk);
      sdo_req = 1'b1;
      sdo_write = wr;
      sdo_index = access_index;
      sdo_subindex = sub;
      sdo_wdata = wd;
      @(negedge clk);
      sdo_req = 1'b0;
      for (i = 0; i < 4 && sdo_done !== 1'b1; i++) @(negedge clk);
      if (i == 4) begin
         tb_top.n_errors++;
         tb_top.tally_and_finish();
      end
      rd = sdo_rdata;
      code = sdo_abort_code;
      // stale qualifiers are inverted so nothing can lean on them between accesses
      sdo_write = ~sdo_write;
      sdo_index = ~sdo_index;
      sdo_subindex = ~sdo_subindex;
      sdo_wdata = ~sdo_wdata;
   endtask : access
endmodule : sdo_master_model

// ### bench/tb_top.sv
// self-checking bench for the diagnosis history object
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, msg_valid = 1'b0;
   logic        sdo_req, sdo_write, sdo_done, sdo_abort, msg_ready, emcy_valid;
   logic [15:0] sdo_index, sdo_wdata, sdo_rdata, rd;
   logic [7:0]  sdo_subindex, msg_payload = 8'h00, pay;
   logic [1:0]  msg_class = 2'h0, cls;
   logic [31:0] sdo_abort_code, code;
   logic [9:0]  emcy_entry;
   logic [15:0] rst_exp [6] = '{16'h0000, 16'h00FA, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   int          n_errors = 0, n_checks = 0, k;
   always #2 clk = ~clk;
   diag_history_log dut_u (.clk(clk), .nrst(nrst), .ce(ce), .sdo_req(sdo_req), .sdo_write(sdo_write),
      .sdo_index(sdo_index), .sdo_subindex(sdo_subindex), .sdo_wdata(sdo_wdata), .sdo_done(sdo_done),
      .sdo_rdata(sdo_rdata), .sdo_abort(sdo_abort), .sdo_abort_code(sdo_abort_code), .msg_valid(msg_valid),
      .msg_class(msg_class), .msg_payload(msg_payload), .msg_ready(msg_ready), .emcy_valid(emcy_valid),
      .emcy_entry(emcy_entry));
   sdo_master_model master_u (.clk(clk), .sdo_done(sdo_done), .sdo_rdata(sdo_rdata),
      .sdo_abort_code(sdo_abort_code), .sdo_req(sdo_req), .sdo_write(sdo_write), .sdo_index(sdo_index),
      .sdo_subindex(sdo_subindex), .sdo_wdata(sdo_wdata));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] sub, input logic [15:0] exp);
      master_u.access(1'b0, sub, 16'h0000, rd, code);
      chk({16'h0000, rd}, {16'h0000, exp});
   endtask : rdc
   task automatic wrc(input logic [7:0] sub, input logic [15:0] wd, input logic [31:0] exp);
      master_u.access(1'b1, sub, wd, rd, code);
      chk(code, exp);
   endtask : wrc
   // random class and content; a refused offer stays up until taken
   task automatic post();
      int i;
      cls = 2'($urandom % 4);
      pay = 8'($urandom);
      @(negedge clk);
      msg_valid = 1'b1;
      msg_class = cls;
      msg_payload = pay;
      for (i = 0; i < 8 && msg_ready !== 1'b1; i++) @(negedge clk);
      if (i == 8) begin
         n_errors++;
         tally_and_finish();
      end
      @(negedge clk);
      msg_valid = 1'b0;
      msg_payload = ~pay;
   endtask : post
   function automatic logic [7:0] slot_of(input int n);
      return 8'(6 + (n - 1) % diag_history_pkg::CAPACITY);
   endfunction : slot_of
   initial begin
      void'($urandom(82));
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      for (k = 0; k < 6; k++) rdc(8'(k), rst_exp[k]);
      wrc(8'h01, 16'h0005, diag_history_pkg::ABORT_READ_ONLY);
      wrc(8'h05, 16'hFFE1, 32'h0);
      rdc(8'h05, 16'h0001);
      // a write to a foreign object must be refused and leave the flag word alone
      master_u.access_index = 16'h10F4;
      wrc(8'h05, 16'h001E, diag_history_pkg::ABORT_NO_OBJECT);
      master_u.access_index = diag_history_pkg::HISTORY_INDEX;
      rdc(8'h05, 16'h0001);
      for (k = 1; k <= 3; k++) begin
         post();
         chk(32'(emcy_entry), {22'h0, cls, pay});
         chk(32'(emcy_valid), 32'h1);
         rdc(8'h00, 16'(slot_of(k)));
         rdc(8'h02, 16'(slot_of(k)));
         rdc(8'h04, 16'h0001);
         rdc(slot_of(k), {6'h00, cls, pay});
         rdc(8'h04, 16'h0000);
      end
      for (k = 1; k <= 3; k++) begin
         wrc(8'h05, 16'(1 << k), 32'h0);
         @(negedge clk);
         msg_valid = 1'b1;
         msg_class = 2'(k - 1);
         @(negedge clk);
         msg_valid = 1'b0;
         rdc(8'h02, 16'h0008);
      end
      wrc(8'h05, 16'h0000, 32'h0);
      // a stalled clock enable must keep the newest-message pointer
      @(negedge clk);
      ce = 1'b0;
      repeat (2) @(negedge clk);
      ce = 1'b1;
      rdc(8'h02, 16'h0008);
      for (k = 1; k <= 5; k++) wrc(8'h03, 16'(k), diag_history_pkg::ABORT_TOO_LOW);
      wrc(8'h03, 16'h00C8, diag_history_pkg::ABORT_RANGE);
      wrc(8'h03, 16'h0007, 32'h0);
      rdc(8'h03, 16'h0007);
      // an unread message so that the clear below has a new-message mark to drop
      post();
      wrc(8'h03, 16'h0000, 32'h0);
      rdc(8'h02, 16'h0000);
      rdc(8'h03, 16'h0000);
      rdc(8'h04, 16'h0000);
      for (k = 1; k <= 251; k++) post();
      chk(32'(emcy_valid), 32'h0);
      rdc(8'h02, 16'(slot_of(251)));
      rdc(8'h00, 16'h00FF);
      rdc(8'h05, 16'h0020);
      rdc(8'h03, 16'h0000);
      wrc(8'h03, 16'h0000, 32'h0);
      rdc(8'h05, 16'h0000);
      wrc(8'h05, 16'h0010, 32'h0);
      rdc(8'h03, 16'h0000);
      for (k = 1; k <= 251; k++) post();
      rdc(8'h02, 16'h00FF);
      rdc(8'h05, 16'h0030);
      wrc(8'h03, 16'h000A, 32'h0);
      rdc(8'h03, 16'h000A);
      rdc(8'h04, 16'h0001);
      wrc(8'h03, 16'h0000, 32'h0);
      rdc(8'h06, 16'h0000);
      rdc(8'h0A, 16'h0000);
      rdc(8'h02, 16'h00FF);
      tally_and_finish();
   end
endmodule : tb_top
